// ===== hdl/cblmw_top.sv
// APB register file, secondary latency timer and memory window decode
`timescale 1ns/1ps
module cblmw_top
    import cblmw_pkg::*;
(
    input wire logic pclk,             // 100 MHz clock, stands in for CCLK
    input wire logic presetn,          // Asynchronous reset, active low
    input wire logic psel,             // APB select
    input wire logic penable,          // APB access phase
    input wire logic pwrite,           // APB direction
    input wire logic [31:0] paddr,     // APB byte address
    input wire logic [31:0] pwdata,    // APB write data
    output logic [31:0] prdata,        // APB read data
    output logic pready,               // APB ready
    output logic pslverr,              // APB error
    input wire logic cclk_en,          // One pulse per CardBus clock
    input wire logic frame_start,      // Bridge asserts CFRAME as initiator
    input wire logic data_phase_end,   // A data phase of own transaction closes
    input wire logic xact_done,        // Own transaction has ended
    output logic lat_expired,          // Latency counter ran out
    output logic stop_xact,            // End the transaction at this data phase
    input wire logic [31:0] host_addr, // Host memory address under decode
    input wire logic [31:0] card_addr, // CardBus memory address under decode
    output logic host_fwd,             // Host access falls in a window
    output logic host_fwd_pf,          // That window is prefetchable
    output logic card_fwd              // Card access falls outside all windows
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Window hit: enabled when base or limit nonzero, limit covers its page
    function automatic logic win_hit(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] l);
        logic en;
        en = (b != WIN_RST) || (l != WIN_RST);
        win_hit = en && (a >= b) && (a <= (l | PAGE_TOP));
    endfunction : win_hit

    // Register index from a byte address; upper and lower bits must be clean
    function automatic logic [8:0] reg_index(input logic [31:0] a);
        reg_index = (a[31:10] == 22'h000000 && a[1:0] == 2'h0) ? {1'b1, a[9:2]} : 9'h000;
    endfunction : reg_index

    ////////////////////////////////////////////////////////////////////////////
    // State

    cblmw_state_t st_reg;  // Registered state
    cblmw_state_t st_next; // Next state
    logic [8:0] idx;       // Decoded index with valid bit
    logic wr_en;           // Write takes effect this edge
    logic hit0;            // Host address in window 0
    logic hit1;            // Host address in window 1

    assign idx = reg_index(paddr);
    assign wr_en = psel && penable && pready && pwrite && !st_reg.pslverr;
    assign hit0 = win_hit(host_addr, st_reg.base0, st_reg.lim0);
    assign hit1 = win_hit(host_addr, st_reg.base1, st_reg.lim1);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Bus slave, latency timer and decode all fill one copy of the state
    always_comb
    begin
        st_next = st_reg;
        // Setup cycle: answer one cycle later, read data and error prepared now
        st_next.pready = psel && !penable;
        if (psel && !penable)
        begin
            st_next.pslverr = 1'b0;
            case (idx)
                {1'b1, IDX_LAT}: st_next.prdata = {24'h000000, st_reg.lat};
                {1'b1, IDX_BASE0}: st_next.prdata = st_reg.base0;
                {1'b1, IDX_LIM0}: st_next.prdata = st_reg.lim0;
                {1'b1, IDX_BASE1}: st_next.prdata = st_reg.base1;
                {1'b1, IDX_LIM1}: st_next.prdata = st_reg.lim1;
                {1'b1, IDX_CTRL}: st_next.prdata = {22'h000000, st_reg.pf, 8'h00};
                {1'b1, IDX_STAT}: st_next.prdata = {22'h000000, st_reg.stop, st_reg.expired,
                                                    st_reg.cnt};
                default:
                begin
                    // Unmapped: read zero and flag an error
                    st_next.prdata = 32'h00000000;
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
        else if (!psel)
        begin
            st_next.pslverr = 1'b0;
        end
        // Writes land only at the edge that completes the access
        if (wr_en)
        begin
            case (idx)
                {1'b1, IDX_LAT}: st_next.lat = pwdata[7:0];
                // Low twelve bits never stored, so always read zero
                {1'b1, IDX_BASE0}: st_next.base0 = pwdata & PAGE_MASK;
                {1'b1, IDX_LIM0}: st_next.lim0 = pwdata & PAGE_MASK;
                {1'b1, IDX_BASE1}: st_next.base1 = pwdata & PAGE_MASK;
                {1'b1, IDX_LIM1}: st_next.lim1 = pwdata & PAGE_MASK;
                {1'b1, IDX_CTRL}: st_next.pf = pwdata[CTRL_PF1:CTRL_PF0];
                default:
                begin
                    // Status and unmapped words ignore writes
                    st_next.pf = st_reg.pf;
                end
            endcase
        end
        // Latency timer: counts CCLK from CFRAME; a zero count expires at once
        if (frame_start)
        begin
            st_next.run = 1'b1;
            st_next.cnt = 8'h00;
            st_next.expired = (st_reg.lat == 8'h00);
            st_next.stop = 1'b0;
        end
        else if (xact_done)
        begin
            st_next.run = 1'b0;
            st_next.expired = 1'b0;
            st_next.stop = 1'b0;
        end
        else if (st_reg.run)
        begin
            if (cclk_en && st_reg.cnt != CNT_MAX)
            begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end
            if (cclk_en && (st_reg.cnt + 8'h01) >= st_reg.lat)
            begin
                st_next.expired = 1'b1;
            end
            // After expiry the data phase in progress or next is the last
            if (st_reg.expired && data_phase_end)
            begin
                st_next.stop = 1'b1;
            end
        end
        // Forwarding decode, registered so outputs come from flops
        st_next.hfwd = hit0 || hit1;
        st_next.hpf = (hit0 && st_reg.pf[0]) || (hit1 && st_reg.pf[1]);
        st_next.cfwd = !(win_hit(card_addr, st_reg.base0, st_reg.lim0) ||
                         win_hit(card_addr, st_reg.base1, st_reg.lim1));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Reset to documented defaults; windows start disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
            st_reg.cfwd <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign lat_expired = st_reg.expired;
    assign stop_xact = st_reg.stop;
    assign host_fwd = st_reg.hfwd;
    assign host_fwd_pf = st_reg.hpf;
    assign card_fwd = st_reg.cfwd;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_lat_write;
        psel && penable && pready && pwrite && !pslverr && paddr == {22'h0, IDX_LAT, 2'h0};
    endsequence
    sequence s_expire_phase;
        lat_expired && data_phase_end && !frame_start && !xact_done;
    endsequence

    a_lat_store: assert property (s_lat_write |=> st_reg.lat == $past(pwdata[7:0]))
        else $error("latency count not stored");
    a_cnt_start: assert property (frame_start |=> st_reg.run && st_reg.cnt == 8'h00)
        else $error("counter did not start on frame");
    a_cnt_step: assert property (st_reg.run && cclk_en && st_reg.cnt != CNT_MAX &&
                                 !frame_start && !xact_done
                                 |=> st_reg.cnt == $past(st_reg.cnt) + 8'h01)
        else $error("counter did not advance");
    a_stop_after: assert property (s_expire_phase |=> stop_xact)
        else $error("no stop after expiry data phase");
    a_stop_cause: assert property ($rose(stop_xact) |-> $past(lat_expired))
        else $error("stop without expiry");
    a_base_low: assert property (st_reg.base0[11:0] == 12'h000 &&
                                 st_reg.base1[11:0] == 12'h000)
        else $error("base low bits nonzero");
    a_base_store: assert property (psel && penable && pready && pwrite &&
                                   paddr == {22'h0, IDX_BASE0, 2'h0}
                                   |=> st_reg.base0[31:PAGE_LSB] == $past(pwdata[31:PAGE_LSB]))
        else $error("base bits not stored");
    a_win_off: assert property (st_reg.base0 == WIN_RST && st_reg.lim0 == WIN_RST &&
                                st_reg.base1 == WIN_RST && st_reg.lim1 == WIN_RST
                                |=> !host_fwd && card_fwd)
        else $error("disabled window claimed");
    a_win_hit: assert property (st_reg.base0 != WIN_RST &&
                                host_addr >= st_reg.base0 &&
                                host_addr <= (st_reg.lim0 | PAGE_TOP) |=> host_fwd)
        else $error("window 0 missed");
    // Checked from the window bounds, not from the decode's own hit terms
    a_pf_win0: assert property (st_reg.base0 != WIN_RST && st_reg.pf[0] &&
                                host_addr >= st_reg.base0 &&
                                host_addr <= (st_reg.lim0 | PAGE_TOP) |=> host_fwd_pf)
        else $error("window 0 prefetch missed");
    a_pf_sel: assert property (host_fwd_pf |-> host_fwd)
        else $error("prefetch without hit");

endmodule : cblmw_top

// ===== hdl/cblmw_pkg.sv
// Constants, register map and state type for the latency timer and memory window block
// Summary of operation
// - Counter starts with CFRAME, advances per CCLK
// - Expiry ends own transaction after next data phase
// - Latency count 8-bit RW, offset 1Bh, reset 00h
// - Window base bits 31-12 writable, 4 KB aligned
// - Base bits 11-0 read zero, ignore writes
// - Windows steer host-to-card and card-to-host forwarding
// - Control bits 8, 9 mark windows prefetchable
// - Base and limit both zero disables window
package cblmw_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_LAT = 8'h1b;
    localparam logic [7:0] IDX_BASE0 = 8'h1c;
    localparam logic [7:0] IDX_LIM0 = 8'h1d;
    localparam logic [7:0] IDX_BASE1 = 8'h1e;
    localparam logic [7:0] IDX_LIM1 = 8'h1f;
    localparam logic [7:0] IDX_CTRL = 8'h20;
    localparam logic [7:0] IDX_STAT = 8'h21;
    // Field layout
    localparam int PAGE_LSB = 12;
    localparam int CTRL_PF0 = 8;
    localparam int CTRL_PF1 = 9;
    localparam logic [31:0] PAGE_MASK = 32'hfffff000;
    localparam logic [31:0] PAGE_TOP = 32'h00000fff;
    // Reset values and counter ceiling
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [31:0] WIN_RST = 32'h00000000;
    localparam logic [7:0] CNT_MAX = 8'hff;

    // Whole state of the block, registered as one word
    typedef struct packed {
        logic [7:0] lat;      // Programmed latency count
        logic [31:0] base0;   // Window 0 base
        logic [31:0] lim0;    // Window 0 limit
        logic [31:0] base1;   // Window 1 base
        logic [31:0] lim1;    // Window 1 limit
        logic [1:0] pf;       // Prefetch select, windows 1:0
        logic [7:0] cnt;      // Running latency counter
        logic run;            // Bridge owns the CardBus
        logic expired;        // Counter ran out
        logic stop;           // End transaction at this data phase
        logic hfwd;           // Host access forwarded to card
        logic hpf;            // Forwarded access is prefetchable
        logic cfwd;           // Card access forwarded to host
        logic [31:0] prdata;  // Read data
        logic pready;         // Access phase answer
        logic pslverr;        // Unmapped address
    } cblmw_state_t;
endpackage : cblmw_pkg

// ===== verification/cblmw_card_model.sv
// Card-side model: card clock enables and prompt or slow data phase completion
`timescale 1ns/1ps
module cblmw_card_model (
    input wire logic pclk,      // Bench clock
    input wire logic presetn,   // Async reset, active low
    input wire logic run,       // Card clock runs only inside a frame
    input wire logic req,       // Start one data phase
    input wire logic [3:0] dly, // Wait states before the target is ready
    output logic cclk_en,       // One pulse per card clock
    output logic dpe            // Data phase closes
);
    logic [4:0] cnt_reg; // Countdown to target ready
    ////////////////////////////////////////////////////////////////////////
    // Clock stands still between frames, so no stray counting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 5'h00;
            cclk_en <= 1'b0;
        end
        else
        begin
            cclk_en <= run;
            if (req)
                cnt_reg <= {1'b0, dly} + 5'h01;
            else if (cnt_reg != 5'h00)
                cnt_reg <= cnt_reg - 5'h01;
        end
    end
    assign dpe = (cnt_reg == 5'h01); // Pulse lasts one cycle
endmodule : cblmw_card_model

// ===== verification/cblmw_top_tb.sv
// Self-checking bench for the latency timer and memory window block
`timescale 1ns/1ps
module cblmw_top_tb
    import cblmw_pkg::*;
;
    logic pclk = 1'b0; // 100 MHz
    logic presetn, psel, penable, pwrite, frame_start, xact_done, run, req;
    logic [31:0] paddr, pwdata, prdata, host_addr, card_addr, r;
    logic pready, pslverr, cclk_en, dpe, lat_expired, stop_xact, e;
    logic host_fwd, host_fwd_pf, card_fwd;
    logic [3:0] dly;
    int n_errors = 0;
    int check_count = 0;
    // Flags: expired, stop, host hit, prefetch, card to host
    wire logic [31:0] flags = {27'h0, lat_expired, stop_xact, host_fwd, host_fwd_pf, card_fwd};
    logic [31:0] av[8] = '{32'h12345000, 32'h12346fff, 32'h12347000, 32'h12344fff,
        32'h40000fff, 32'h40001000, 32'h40000000, 32'h12345000};
    logic [31:0] ev[8] = '{32'h6, 32'h6, 32'h1, 32'h1, 32'h4, 32'h1, 32'h6, 32'h4};
    always #5 pclk = ~pclk;
    cblmw_top cblmw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cclk_en(cclk_en), .frame_start(frame_start), .data_phase_end(dpe),
        .xact_done(xact_done), .lat_expired(lat_expired), .stop_xact(stop_xact),
        .host_addr(host_addr), .card_addr(card_addr), .host_fwd(host_fwd),
        .host_fwd_pf(host_fwd_pf), .card_fwd(card_fwd));
    cblmw_card_model cblmw_card_model_inst (.pclk(pclk), .presetn(presetn), .run(run),
        .req(req), .dly(dly), .cclk_en(cclk_en), .dpe(dpe));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, x);
        end
    endtask : chk
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            end_sim();
        end
        // Idle cycle, so a following call never reassigns psel in this time step
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        apb(1'b1, {22'h0, i, 2'b00}, d);
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [31:0] x);
        apb(1'b0, {22'h0, i, 2'b00}, 32'h0);
        chk(r, x);
    endtask : rd
    task automatic look(input logic [31:0] a, input logic [31:0] x);
        host_addr <= a;
        card_addr <= a;
        repeat (2) @(posedge pclk);
        chk(flags, x);
    endtask : look
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, frame_start, xact_done} = '0;
        {host_addr, card_addr, run, req, dly} = '0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then disabled windows: no host hit, card access forwarded to host
        rd(IDX_LAT, 32'h0);
        rd(IDX_BASE0, 32'h0);
        look(32'h00000800, 32'h1);
        $display("test 1 done");
        // Field access and an unmapped address
        wr(IDX_LAT, 32'h000000a5);
        rd(IDX_LAT, 32'h000000a5);
        wr(IDX_BASE0, 32'h12345fff);
        rd(IDX_BASE0, 32'h12345000);
        apb(1'b0, 32'h00000200, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test 2 done");
        // Window edges and prefetch selection
        wr(IDX_LIM0, 32'h12346000);
        wr(IDX_CTRL, 32'h00000100);
        wr(IDX_BASE1, 32'h40000000);
        wr(IDX_LIM1, 32'h40000000);
        for (int i = 0; i < 8; i++)
        begin
            if (i == 6)
                wr(IDX_CTRL, 32'h00000200);
            look(av[i], ev[i]);
        end
        $display("test 3 done");
        // Latency expiry, early phase ignored, slow target phase ends it
        wr(IDX_LAT, 32'h00000040);
        rd(IDX_LAT, 32'h00000040);
        wr(IDX_LAT, 32'h00000002);
        look(32'h0, 32'h1);
        frame_start <= 1'b1;
        run <= 1'b1;
        req <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        req <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(flags, 32'h01);
        @(posedge pclk);
        chk(flags, 32'h11);
        dly <= 4'h3;
        req <= 1'b1;
        @(posedge pclk);
        req <= 1'b0;
        for (int k = 0; k < 16 && dpe !== 1'b1; k++)
            @(posedge pclk);
        if (dpe !== 1'b1)
        begin
            n_errors++;
            end_sim();
        end
        chk(flags, 32'h11);
        @(posedge pclk);
        chk(flags, 32'h19);
        xact_done <= 1'b1;
        run <= 1'b0;
        @(posedge pclk);
        xact_done <= 1'b0;
        @(posedge pclk);
        chk(flags, 32'h01);
        // Nine card clocks passed between frame start and transaction end
        rd(IDX_STAT, 32'h00000009);
        wr(IDX_STAT, 32'hffffffff);
        rd(IDX_STAT, 32'h00000009);
        $display("test 4 done");
        end_sim();
    end
endmodule : cblmw_top_tb
